// ==== rtl/fail_safe_monitor_pkg.sv ====
package cmon_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] OFS_OSC_CTRL   = 4'h0;
  localparam logic [3:0] OFS_OSC_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_FLAG   = 4'h8;
  localparam logic [3:0] OFS_IRQ_ENABLE = 4'hc;

  localparam logic [7:0] OSC_CTRL_RESET = 8'h38;
  localparam logic [7:0] OSC_CTRL_WMASK = 8'hfb;
  localparam int         CTRL_PLL_BIT   = 7;
  localparam int         CTRL_FREQ_LSB  = 3;
  localparam int         CTRL_SEL_LSB   = 0;
  localparam int         STAT_START_BIT = 5;
  localparam int         STAT_SRC_LSB   = 1;
  localparam int         STAT_FAIL_BIT  = 0;
  localparam int         FLAG_FAIL_BIT  = 0;
  localparam int         EN_FAIL_BIT    = 0;

  // ==========================================================================
  // Counts
  localparam int         SAMPLE_DIVIDE      = 64;
  localparam logic [4:0] SAMPLE_HALF_LAST   = 5'(SAMPLE_DIVIDE / 2 - 1);
  localparam int         STARTUP_OSC_COUNT  = 1024;
  localparam logic [9:0] STARTUP_LAST       = 10'(STARTUP_OSC_COUNT - 1);

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    MODE_LOW_XTAL  = 3'b000,
    MODE_XTAL      = 3'b001,
    MODE_FAST_XTAL = 3'b010,
    MODE_EXT_CLK   = 3'b011,
    MODE_RC        = 3'b100,
    MODE_INT       = 3'b101
  } osc_mode_t;

  typedef enum logic [1:0] {
    SRC_CFG  = 2'b00,
    SRC_SEC  = 2'b01,
    SRC_INT  = 2'b10,
    SRC_HOLD = 2'b11
  } clk_src_t;

  typedef enum logic [1:0] {
    BAND_LF = 2'b00,
    BAND_MF = 2'b01,
    BAND_HF = 2'b10
  } int_band_t;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN   = 2'b01,
    ST_FAIL  = 2'b10,
    ST_SLEEP = 2'b11
  } fsm_state_t;

  typedef struct packed {
    logic      monitor_enable_cfg;
    logic      cfg_pll_enable;
    osc_mode_t cfg_osc_mode;
  } cfg_word_t;

  typedef struct packed {
    int_band_t  band;
    logic [3:0] code;
    logic       from_hf;
  } int_osc_t;

  // ==========================================================================
  // Decoders
  function automatic clk_src_t decode_select(input logic [1:0] sel);
    decode_select = sel[1] ? SRC_INT : (sel[0] ? SRC_SEC : SRC_CFG);
  endfunction

  function automatic logic is_crystal(input osc_mode_t mode);
    is_crystal = (mode == MODE_LOW_XTAL) || (mode == MODE_XTAL) || (mode == MODE_FAST_XTAL);
  endfunction

  function automatic int_osc_t decode_freq(input logic [3:0] code);
    decode_freq.code    = code;
    decode_freq.band    = code[3] ? BAND_HF : ((code[3:1] == 3'b000) ? BAND_LF : BAND_MF);
    decode_freq.from_hf = code[3] || (code == 4'h3);
    if ((code == 4'h3) || (code[3:1] != 3'b000 && !code[3] && code == 4'h3))
      decode_freq.band = BAND_HF;
  endfunction

endpackage

// ==== rtl/fail_safe_clock_monitor.sv ====
// Function
// - Monitor enabled by config bit, all external modes.
// - No detection until startup timer expires.
// - Sample clock is low-frequency oscillator divided by 64.
// - External falling edge sets latch, sample rise clears.
// - Fail when half sample period has no low.
// - On failure switch internal, set fail flag.
// - Interrupt when fail flag and enable set.
// - Stay internal until software switches back successfully.
// - Fallback frequency comes from frequency select field.
// - Reset or sleep clear fail-safe; a select change alone does not.
// - Select change restarts startup timer, runs internal.
// - Fail-safe also clears when start-up ends, whichever source is selected.
// - Flag sets again if failure persists and the source skips the startup timer.
// - External clock and RC modes skip startup timer.
// - Monitor enable also enables two-speed start-up.
// - Startup status set when running configured clock.
// - Startup timer counts 1024 oscillations for crystals.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns

module fail_safe_clock_monitor
(
  input  wire  logic                 core_clk_in,
  input  wire  logic                 arst_n_in,
  input  wire  cmon_pkg::cfg_word_t  cfg_word_in,
  input  wire  logic                 ext_clk_in,
  input  wire  logic                 lf_osc_in,
  input  wire  logic                 sleep_in,
  input  wire  logic                 wake_in,
  input  wire  logic [3:0]           avs_address_in,
  input  wire  logic                 avs_read_in,
  input  wire  logic                 avs_write_in,
  input  wire  logic [31:0]          avs_writedata_in,
  input  wire  logic [3:0]           avs_byteenable_in,
  output logic [31:0]                avs_readdata_out,
  output logic                       avs_waitrequest_out,
  output cmon_pkg::clk_src_t         sys_clk_src_out,
  output cmon_pkg::int_osc_t         int_osc_out,
  output logic                       pll_enable_out,
  output logic                       fail_safe_out,
  output logic                       irq_out
);
  import cmon_pkg::*;

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic       ext_meta_q;
  logic       ext_sync_q;
  logic       ext_prev_q;
  logic       lf_meta_q;
  logic       lf_sync_q;
  logic       lf_prev_q;
  logic       ext_fall;
  logic       lf_rise;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      lf_meta_q  <= 1'b0;
      lf_sync_q  <= 1'b0;
      lf_prev_q  <= 1'b0;
    end
    else
    begin
      ext_meta_q <= ext_clk_in;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      lf_meta_q  <= lf_osc_in;
      lf_sync_q  <= lf_meta_q;
      lf_prev_q  <= lf_sync_q;
    end
  end

  assign ext_fall = ext_prev_q && !ext_sync_q;
  assign lf_rise  = lf_sync_q && !lf_prev_q;

  // ==========================================================================
  // Sample clock divider
  logic [4:0] div_cnt_q;
  logic       samp_q;
  logic       samp_toggle;
  logic       samp_rise;
  logic       samp_fall;

  assign samp_toggle = lf_rise && (div_cnt_q == SAMPLE_HALF_LAST);
  assign samp_rise   = samp_toggle && !samp_q;
  assign samp_fall   = samp_toggle && samp_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_cnt_q <= 5'h0;
      samp_q    <= 1'b0;
    end
    else if (lf_rise)
    begin
      div_cnt_q <= div_cnt_q + 5'h1;
      if (samp_toggle)
        samp_q <= !samp_q;
    end
  end

  // ==========================================================================
  // Bus slave and registers
  logic [7:0]  ctrl_q;
  logic        flag_q;
  logic        irq_en_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic        wr_fire;
  logic        select_change;
  logic        fail_evt_q;
  logic        fail_raw_q;
  logic        fail_safe_q;
  logic        startup_q;
  clk_src_t    src_q;
  fsm_state_t  state_q;

  assign wr_fire    = avs_write_in && !wait_q && avs_byteenable_in[0];
  assign select_change = wr_fire && (avs_address_in == OFS_OSC_CTRL) &&
                         (avs_writedata_in[CTRL_SEL_LSB +: 2] != ctrl_q[CTRL_SEL_LSB +: 2]);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (avs_address_in)
      OFS_OSC_CTRL:   rd_word[7:0] = ctrl_q;
      OFS_OSC_STATUS:
      begin
        rd_word[STAT_START_BIT]     = startup_q;
        rd_word[STAT_SRC_LSB +: 2]  = src_q;
        rd_word[STAT_FAIL_BIT]      = fail_safe_q;
      end
      OFS_IRQ_FLAG:   rd_word[FLAG_FAIL_BIT] = flag_q;
      OFS_IRQ_ENABLE: rd_word[EN_FAIL_BIT]   = irq_en_q;
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access keeps read data stable at the sampling edge.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wait_q <= !((avs_read_in || avs_write_in) && wait_q);
      if (avs_read_in && wait_q)
        rdata_q <= rd_word;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ctrl_q <= OSC_CTRL_RESET;
    else if (wr_fire && (avs_address_in == OFS_OSC_CTRL))
      ctrl_q <= avs_writedata_in[7:0] & OSC_CTRL_WMASK;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      irq_en_q <= 1'b0;
    else if (wr_fire && (avs_address_in == OFS_IRQ_ENABLE))
      irq_en_q <= avs_writedata_in[EN_FAIL_BIT];
  end

  // A failure in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      flag_q <= 1'b0;
    else if (fail_evt_q && (state_q == ST_RUN))
      flag_q <= 1'b1;
    else if (wr_fire && (avs_address_in == OFS_IRQ_FLAG))
      flag_q <= avs_writedata_in[FLAG_FAIL_BIT];
  end

  // ==========================================================================
  // Target source decode
  clk_src_t   target;
  logic       ext_target;
  logic       needs_timer;
  logic       monitored;

  always_comb
  begin
    target     = decode_select(ctrl_q[CTRL_SEL_LSB +: 2]);
    ext_target = (target == SRC_SEC) ||
                 ((target == SRC_CFG) && (cfg_word_in.cfg_osc_mode != MODE_INT));
    needs_timer = (target == SRC_SEC) ||
                 ((target == SRC_CFG) && is_crystal(cfg_word_in.cfg_osc_mode));
    monitored  = cfg_word_in.monitor_enable_cfg && ext_target;
  end

  // ==========================================================================
  // Start-up timer and clock state
  logic [9:0] timer_cnt_q;
  fsm_state_t state_d;
  logic       timer_done;

  assign timer_done = ext_fall && (timer_cnt_q == STARTUP_LAST);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_START:
      begin
        if (!ext_target || !needs_timer || timer_done)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (fail_evt_q)
          state_d = ST_FAIL;
      end
      ST_FAIL:  state_d = ST_FAIL;
      ST_SLEEP:
      begin
        if (wake_in)
          state_d = ST_START;
      end
    endcase
    if (select_change && (state_q != ST_SLEEP))
      state_d = ST_START;
    if (sleep_in)
      state_d = ST_SLEEP;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_q <= ST_START;
    else
      state_q <= state_d;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      timer_cnt_q <= 10'h000;
    else if (state_q != ST_START || select_change)
      timer_cnt_q <= 10'h000;
    else if (ext_fall)
      timer_cnt_q <= timer_cnt_q + 10'h001;
  end

  // The fail-safe bit survives the restarted timer so software sees why it runs internal.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      fail_safe_q <= 1'b0;
    else if (sleep_in)
      fail_safe_q <= 1'b0;
    else if (state_q == ST_RUN && fail_evt_q)
      fail_safe_q <= 1'b1;
    else if (state_q == ST_START && state_d == ST_RUN)
      fail_safe_q <= 1'b0;
  end

  // ==========================================================================
  // Fail detector
  logic mon_active;
  logic latch_q;
  logic armed_q;

  assign mon_active = (state_q == ST_RUN) && monitored;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      latch_q <= 1'b0;
    else if (ext_fall)
      latch_q <= 1'b1;
    else if (samp_rise)
      latch_q <= 1'b0;
  end

  // Arming on a sample rise avoids judging a half period that started mid-way.
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      armed_q <= 1'b0;
    else if (!mon_active)
      armed_q <= 1'b0;
    else if (samp_rise)
      armed_q <= 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fail_raw_q <= 1'b0;
      fail_evt_q <= 1'b0;
    end
    else
    begin
      fail_raw_q <= mon_active && armed_q && samp_fall && !latch_q && !ext_fall;
      fail_evt_q <= fail_raw_q && mon_active;
    end
  end

  // ==========================================================================
  // Output registers
  clk_src_t src_d;

  always_comb
  begin
    src_d = SRC_HOLD;
    unique case (state_q)
      ST_START: src_d = !ext_target ? target :
                        (cfg_word_in.monitor_enable_cfg ? SRC_INT : SRC_HOLD);
      ST_RUN:   src_d = target;
      ST_FAIL:  src_d = SRC_INT;
      ST_SLEEP: src_d = SRC_HOLD;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      src_q     <= SRC_HOLD;
      startup_q <= 1'b0;
    end
    else
    begin
      src_q     <= src_d;
      startup_q <= (state_q == ST_RUN) && (target == SRC_CFG);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      int_osc_out    <= decode_freq(OSC_CTRL_RESET[CTRL_FREQ_LSB +: 4]);
      pll_enable_out <= 1'b0;
      irq_out        <= 1'b0;
    end
    else
    begin
      int_osc_out    <= decode_freq(ctrl_q[CTRL_FREQ_LSB +: 4]);
      pll_enable_out <= cfg_word_in.cfg_pll_enable || ctrl_q[CTRL_PLL_BIT];
      irq_out        <= flag_q && irq_en_q;
    end
  end

  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign sys_clk_src_out     = src_q;
  assign fail_safe_out       = fail_safe_q;

  // ==========================================================================
  // Assertions
  sequence s_fail_enter;
    fail_evt_q && (state_q == ST_RUN) && !sleep_in && !select_change;
  endsequence

  sequence s_switch_internal;
    flag_q && (state_q == ST_FAIL) ##1 (src_q == SRC_INT);
  endsequence

  property p_divider;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      $changed(samp_q) |-> $past(lf_rise) && ($past(div_cnt_q) == SAMPLE_HALF_LAST);
  endproperty
  a_divider: assert property (p_divider) else $error("sample clock toggled off count");

  property p_latch;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (ext_fall |=> latch_q) and ((samp_rise && !ext_fall) |=> !latch_q);
  endproperty
  a_latch: assert property (p_latch) else $error("detector latch wrong");

  property p_fail_cause;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      fail_raw_q |-> $past(samp_fall) && !$past(latch_q) && $past(mon_active);
  endproperty
  a_fail_cause: assert property (p_fail_cause) else $error("failure without empty half");

  property p_inactive;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (state_q == ST_START) |=> !fail_raw_q;
  endproperty
  a_inactive: assert property (p_inactive) else $error("detection during start-up");

  property p_fail_switch;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      s_fail_enter |=> s_switch_internal;
  endproperty
  a_fail_switch: assert property (p_fail_switch) else $error("no switch on failure");

  property p_irq;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      ##1 (irq_out == $past(flag_q && irq_en_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");

  property p_retime;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (fail_raw_q && mon_active) |=> fail_evt_q;
  endproperty
  a_retime: assert property (p_retime) else $error("failure not retimed");

  property p_sleep_clear;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      sleep_in |=> (state_q == ST_SLEEP) && !fail_safe_q ##1 (src_q == SRC_HOLD);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear");

  property p_timer_count;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      ($past(state_q) == ST_START) && (state_q == ST_RUN) && $past(needs_timer && ext_target)
      |-> ($past(timer_cnt_q) == STARTUP_LAST);
  endproperty
  a_timer_count: assert property (p_timer_count) else $error("start-up timer short");

  property p_skip_timer;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      ((state_q == ST_START) && ext_target && !needs_timer && !sleep_in && !select_change)
      |=> (state_q == ST_RUN);
  endproperty
  a_skip_timer: assert property (p_skip_timer) else $error("timer not skipped");

endmodule // fail_safe_clock_monitor

// ==== tb/ext_osc_model.sv ====
`timescale 1ns/1ns

// ==========================================================================
// Far-side oscillators
module ext_osc_model
#(
  parameter int EXT_HALF_NS = 8,
  parameter int LF_HALF_NS  = 16
)
(
  input  wire logic run_in,
  output logic      ext_clk_out,
  output logic      lf_osc_out
);
  // A dead oscillator parks high, so the detector never sees a low level.
  initial ext_clk_out = 1'b1;
  initial lf_osc_out  = 1'b0;

  always #(EXT_HALF_NS) ext_clk_out = run_in ? ~ext_clk_out : 1'b1;
  always #(LF_HALF_NS) lf_osc_out = ~lf_osc_out;
endmodule // ext_osc_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns

module tb_top;
  import cmon_pkg::*;

  // ==========================================================================
  // Signals
  logic        core_clk;
  logic        arst_n;
  cfg_word_t   cfg_word;
  logic        ext_run;
  logic        ext_clk;
  logic        lf_osc;
  logic        sleep_req;
  logic        wake_req;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        waitreq;
  clk_src_t    clk_src;
  int_osc_t    int_osc;
  logic        pll_en;
  logic        fail_safe;
  logic        irq;
  int          num_errors = 0;
  int          check_count = 0;

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  fail_safe_clock_monitor dut_u
  (
    .core_clk_in         (core_clk),
    .arst_n_in           (arst_n),
    .cfg_word_in         (cfg_word),
    .ext_clk_in          (ext_clk),
    .lf_osc_in           (lf_osc),
    .sleep_in            (sleep_req),
    .wake_in             (wake_req),
    .avs_address_in      (addr),
    .avs_read_in         (rd),
    .avs_write_in        (wr),
    .avs_writedata_in    (wdata),
    .avs_byteenable_in   (4'hf),
    .avs_readdata_out    (rdata),
    .avs_waitrequest_out (waitreq),
    .sys_clk_src_out     (clk_src),
    .int_osc_out         (int_osc),
    .pll_enable_out      (pll_en),
    .fail_safe_out       (fail_safe),
    .irq_out             (irq)
  );

  ext_osc_model osc_u
  (
    .run_in      (ext_run),
    .ext_clk_out (ext_clk),
    .lf_osc_out  (lf_osc)
  );

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    rd    <= !is_wr;
    wr    <= is_wr;
    @(posedge core_clk);
    while (waitreq !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    q = rdata;
    if (n == 50)
      check("bus_wait", 1, 0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(name, q, exp);
  endtask

  // Bounded wait on either the clock source or the fail-safe flag.
  task automatic wait_for(input logic on_src, input logic [1:0] v, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      if ((on_src ? 2'(clk_src) : {1'b0, fail_safe}) === v)
        return;
    end
  endtask

  task automatic do_reset(input logic mon, input osc_mode_t mode, input logic run);
    arst_n   <= 1'b0;
    cfg_word <= '{monitor_enable_cfg: mon, cfg_pll_enable: 1'b0, cfg_osc_mode: mode};
    ext_run  <= run;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_registers();
    check("int_osc", int_osc, {BAND_MF, 4'h7, 1'b0});
    check("start_src", clk_src, SRC_INT);
    rd_chk("ctrl", OFS_OSC_CTRL, 32'h0000_0038);
    wr_reg(OFS_OSC_STATUS, 32'h0000_00ff);
    rd_chk("status", OFS_OSC_STATUS, 32'h0000_0004);
    rd_chk("unmapped", 4'h2, 32'h0000_0000);
    wr_reg(OFS_OSC_CTRL, 32'h0000_00bc);
    rd_chk("ctrl_bit2", OFS_OSC_CTRL, 32'h0000_00b8);
    check("pll", pll_en, 1'b1);
    wr_reg(OFS_OSC_CTRL, 32'h0000_0008);
    repeat (2) @(posedge core_clk);
    check("int_osc_lf", int_osc, {BAND_LF, 4'h1, 1'b0});
    wr_reg(OFS_OSC_CTRL, 32'h0000_0038);
    repeat (2) @(posedge core_clk);
    check("pll_off", pll_en, 1'b0);
  endtask

  task automatic t_startup();
    repeat (3800) @(posedge core_clk);
    check("timer_src", clk_src, SRC_INT);
    check("timer_fs", fail_safe, 1'b0);
    wait_for(1'b1, SRC_CFG, 800);
    check("run_src", clk_src, SRC_CFG);
    rd_chk("run_status", OFS_OSC_STATUS, 32'h0000_0020);
  endtask

  task automatic t_failure();
    repeat (600) @(posedge core_clk);
    wr_reg(OFS_OSC_CTRL, 32'h0000_0078);
    wr_reg(OFS_IRQ_ENABLE, 32'h0000_0001);
    check("fallback", int_osc, {BAND_HF, 4'hf, 1'b1});
    ext_run <= 1'b0;
    repeat (240) @(posedge core_clk);
    check("early", fail_safe, 1'b0);
    wait_for(1'b0, 2'b01, 700);
    check("fail", fail_safe, 1'b1);
    repeat (2) @(posedge core_clk);
    check("fail_src", clk_src, SRC_INT);
    check("irq", irq, 1'b1);
    rd_chk("flag", OFS_IRQ_FLAG, 32'h0000_0001);
    wr_reg(OFS_IRQ_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    check("irq_mask", irq, 1'b0);
  endtask

  task automatic t_switch_back();
    ext_run <= 1'b1;
    repeat (300) @(posedge core_clk);
    check("stay_int", clk_src, SRC_INT);
    wr_reg(OFS_IRQ_FLAG, 32'h0000_0000);
    wr_reg(OFS_OSC_CTRL, 32'h0000_0079);
    repeat (1000) @(posedge core_clk);
    check("restart_src", clk_src, SRC_INT);
    check("restart_fs", fail_safe, 1'b1);
    wait_for(1'b1, SRC_SEC, 4000);
    check("sec_src", clk_src, SRC_SEC);
    check("cleared", fail_safe, 1'b0);
    rd_chk("flag_clr", OFS_IRQ_FLAG, 32'h0000_0000);
  endtask

  task automatic t_sleep();
    repeat (600) @(posedge core_clk);
    ext_run <= 1'b0;
    wait_for(1'b0, 2'b01, 1000);
    check("refail", fail_safe, 1'b1);
    rd_chk("reflag", OFS_IRQ_FLAG, 32'h0000_0001);
    wr_reg(OFS_IRQ_FLAG, 32'h0000_0000);
    sleep_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("sleep_clr", fail_safe, 1'b0);
    wake_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    repeat (1400) @(posedge core_clk);
    check("wake_src", clk_src, SRC_INT);
    rd_chk("no_detect", OFS_IRQ_FLAG, 32'h0000_0000);
  endtask

  task automatic t_ext_clock();
    do_reset(1'b1, MODE_EXT_CLK, 1'b1);
    repeat (4) @(posedge core_clk);
    check("extclk_src", clk_src, SRC_CFG);
    ext_run <= 1'b0;
    wait_for(1'b0, 2'b01, 1400);
    check("extclk_fail", fail_safe, 1'b1);
    wr_reg(OFS_OSC_CTRL, 32'h0000_003b);
    repeat (3) @(posedge core_clk);
    check("sel_int", clk_src, SRC_INT);
    do_reset(1'b0, MODE_EXT_CLK, 1'b0);
    repeat (1400) @(posedge core_clk);
    check("no_monitor", fail_safe, 1'b0);
  endtask

  // ==========================================================================
  // Sequence and watchdog
  initial
  begin
    sleep_req <= 1'b0;
    wake_req  <= 1'b0;
    addr      <= 4'h0;
    rd        <= 1'b0;
    wr        <= 1'b0;
    wdata     <= 32'h0000_0000;
    do_reset(1'b1, MODE_XTAL, 1'b1);
    // The clock source output is registered, so the first update shows one edge later.
    repeat (2) @(posedge core_clk);
    t_registers();
    t_startup();
    t_failure();
    t_switch_back();
    t_sleep();
    t_ext_clock();
    wrap_up();
  end

  // The whole run needs about 14000 cycles; this allows over three times that.
  initial
  begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule // tb_top
